// file: include/cbi_cfg.svh
// Address map, field positions, reset values and sizes of the cache and bus block
`ifndef CBI_CFG_SVH
`define CBI_CFG_SVH
`define CBI_REG_CTRL 4'h0
`define CBI_REG_PORT 4'h4
`define CBI_REG_STAT 4'h8
`define CBI_CTRL_RST 32'h0000_0000
`define CBI_PORT_RST 32'h0000_0000
`define CBI_WB_DEPTH 3'h4
`define CBI_IC_LINES 128
`define CBI_IC_WORDS 512
`define CBI_DC_LINES 128
`define CBI_LINE_WORDS 4
`define CBI_WSEL 3:2
`define CBI_LINE_HI 31:4
`define CBI_IC_LIDX 10:4
`define CBI_IC_TAG 31:11
`define CBI_DC_IDX 8:2
`define CBI_DC_QIDX 8:4
`define CBI_DC_TAG 31:9
`define CBI_REGION 31:30
`define CBI_MASK32 32'hFFFF_FFFF
`define CBI_MASK16 32'h0000_FFFF
`define CBI_MASK8 32'h0000_00FF
`endif

// file: include/cbi_pkg.sv
// Types shared by the cache and bus block
package cbi_pkg;
  typedef enum logic [1:0] {CBI_PW32, CBI_PW16, CBI_PW8, CBI_PWRSV} cbi_pw_t;
  typedef enum logic [1:0] {CBI_SM_BOTH, CBI_SM_READ, CBI_SM_WRITE, CBI_SM_NONE} cbi_sm_t;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_HOLD, ST_DATA, ST_FILL, ST_TURN, ST_GRANT} cbi_st_t;
  typedef struct packed {
    logic [24:0] rsv;
    cbi_sm_t strobeMode;
    logic [1:0] turnExtra;
    logic burst;
    logic extHold;
    logic refill4;
  } cbi_ctrl_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be;
  } cbi_wbent_t;
endpackage

// file: hdl/cbi_cache_bus.sv
// Instruction and data caches, write and read buffers, multiplexed bus unit
`timescale 1ns/1ps
`include "cbi_cfg.svh"

module cbi_cache_bus
  import cbi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [31:0] avWriteData,
  output logic [31:0] avReadData,
  output logic avWaitRequest,
  input wire logic ifReq,
  input wire logic [31:0] ifAddr,
  output logic [31:0] ifData,
  output logic ifValid,
  input wire logic dReq,
  input wire logic dWrite,
  input wire logic dUncached,
  input wire logic [31:0] dAddr,
  input wire logic [31:0] dWriteData,
  input wire logic [3:0] dByteEn,
  output logic [31:0] dReadData,
  output logic dValid,
  output logic dStall,
  input wire logic [31:0] adIn,
  output logic [31:0] adOut,
  output logic adOe,
  output logic ale,
  output logic rdN,
  output logic wrN,
  output logic [3:0] byteEnN,
  output logic memStrobeN,
  output logic ctlOe,
  input wire logic ackIn,
  input wire logic busReq,
  output logic busGnt
);

  // Register file
  cbi_ctrl_t ctrl, next_ctrl;
  logic [31:0] portCfg, next_portCfg;
  logic [31:0] next_avReadData;
  logic next_avWaitRequest;

  // Cache arrays
  logic [31:0] icData [0:`CBI_IC_WORDS-1];
  logic [20:0] icTag [0:`CBI_IC_LINES-1];
  logic [31:0] dcData [0:`CBI_DC_LINES-1];
  logic [22:0] dcTag [0:`CBI_DC_LINES-1];
  logic [`CBI_IC_LINES-1:0] icVld, next_icVld;
  logic [`CBI_DC_LINES-1:0] dcVld, next_dcVld;

  // Bus engine state
  cbi_st_t st, next_st;
  cbi_wbent_t wbuf [0:3];
  cbi_wbent_t next_wbuf [0:3];
  logic [1:0] wbHead, next_wbHead, wbTail, next_wbTail;
  logic [2:0] wbCount, next_wbCount;
  logic [31:0] rbuf [0:3];
  logic [31:0] next_rbuf [0:3];
  logic [1:0] wordCnt, next_wordCnt, beatCnt, next_beatCnt, turnCnt, next_turnCnt;
  logic [31:0] asmWord, next_asmWord, curAddr, next_curAddr, curWData, next_curWData;
  logic [3:0] curBe, next_curBe;
  logic curWrite, next_curWrite, curQuad, next_curQuad, curIsIf, next_curIsIf, curFill, next_curFill;
  logic [31:0] next_ifData, next_dReadData, next_adOut;
  logic next_ifValid, next_dValid, next_dStall, next_adOe, next_ale, next_rdN, next_wrN;
  logic [3:0] next_byteEnN;
  logic next_memStrobeN, next_ctlOe, next_busGnt;

  // Lookups and strobes for the arrays
  logic icHit, dcHit, fillIc, fillDc, dcStoreEn;
  logic [31:0] dcMerged;

  // Port width of the region holding an address
  function automatic cbi_pw_t widthOf(input logic [31:0] a, input logic [31:0] cfg);
    logic [1:0] code;
    code = cfg[{3'b000, a[`CBI_REGION]} * 2 +: 2];
    widthOf = cbi_pw_t'(code);
  endfunction

  // Byte offset of a beat within its word
  function automatic logic [1:0] beatOff(input cbi_pw_t pw, input logic [1:0] beat);
    unique case (pw)
      CBI_PW16: beatOff = {beat[0], 1'b0};
      CBI_PW8: beatOff = beat;
      default: beatOff = 2'b00;
    endcase
  endfunction

  // Number of the last beat of a word
  function automatic logic [1:0] lastBeat(input cbi_pw_t pw);
    unique case (pw)
      CBI_PW16: lastBeat = 2'b01;
      CBI_PW8: lastBeat = 2'b11;
      default: lastBeat = 2'b00;
    endcase
  endfunction

  // Lane mask of the data carried by one beat
  function automatic logic [31:0] laneMask(input cbi_pw_t pw);
    unique case (pw)
      CBI_PW16: laneMask = `CBI_MASK16;
      CBI_PW8: laneMask = `CBI_MASK8;
      default: laneMask = `CBI_MASK32;
    endcase
  endfunction

  // Hit detection on physical tags
  assign icHit = icVld[ifAddr[`CBI_IC_LIDX]] && icTag[ifAddr[`CBI_IC_LIDX]] == ifAddr[`CBI_IC_TAG];
  assign dcHit = dcVld[dAddr[`CBI_DC_IDX]] && dcTag[dAddr[`CBI_DC_IDX]] == dAddr[`CBI_DC_TAG];
  assign fillIc = (st == ST_FILL) && curIsIf;
  assign fillDc = (st == ST_FILL) && !curIsIf && curFill;
  assign dcStoreEn = dReq && dWrite && !dValid && !dStall && !dUncached && dcHit;

  // Byte merge of a store into a hit line
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      dcMerged[b*8 +: 8] = dByteEn[b] ? dWriteData[b*8 +: 8] : dcData[dAddr[`CBI_DC_IDX]][b*8 +: 8];
  end

  // Cache array writes
  always_ff @(posedge clk)
  begin
    if (fillIc)
    begin
      for (int i = 0; i < `CBI_LINE_WORDS; i++)
        icData[{curAddr[`CBI_IC_LIDX], 2'(i)}] <= rbuf[i];
      icTag[curAddr[`CBI_IC_LIDX]] <= curAddr[`CBI_IC_TAG];
    end
    if (fillDc)
    begin
      for (int i = 0; i < `CBI_LINE_WORDS; i++)
        if (curQuad || 2'(i) == curAddr[`CBI_WSEL])
        begin
          dcData[{curAddr[`CBI_DC_QIDX], 2'(i)}] <= rbuf[i];
          dcTag[{curAddr[`CBI_DC_QIDX], 2'(i)}] <= curAddr[`CBI_DC_TAG];
        end
    end
    else if (dcStoreEn)
      dcData[dAddr[`CBI_DC_IDX]] <= dcMerged;
  end

  // Avalon slave, one wait cycle per access
  always_comb
  begin
    next_ctrl = ctrl;
    next_portCfg = portCfg;
    next_avReadData = avReadData;
    next_avWaitRequest = !((avRead || avWrite) && avWaitRequest);
    if (avWrite && !avWaitRequest)
    begin
      if (avAddress == `CBI_REG_CTRL)
        next_ctrl = cbi_ctrl_t'(avWriteData);
      else if (avAddress == `CBI_REG_PORT)
        next_portCfg = avWriteData;
    end
    if (avRead && avWaitRequest)
    begin
      unique case (avAddress)
        `CBI_REG_CTRL: next_avReadData = ctrl;
        `CBI_REG_PORT: next_avReadData = portCfg;
        `CBI_REG_STAT: next_avReadData = {27'h000_0000, busGnt, (st != ST_IDLE), wbCount};
        default: next_avReadData = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl <= cbi_ctrl_t'(`CBI_CTRL_RST);
      portCfg <= `CBI_PORT_RST;
      avReadData <= 32'h0000_0000;
      avWaitRequest <= 1'b1;
    end
    else
    begin
      ctrl <= next_ctrl;
      portCfg <= next_portCfg;
      avReadData <= next_avReadData;
      avWaitRequest <= next_avWaitRequest;
    end
  end

  // Core service, buffers and bus sequencing
  always_comb
  begin
    cbi_pw_t pw;
    cbi_pw_t npw;
    logic [1:0] off;
    logic [31:0] word;
    logic push;
    logic pop;
    pw = widthOf(curAddr, portCfg);
    npw = pw;
    off = beatOff(pw, beatCnt);
    word = asmWord | ((adIn & laneMask(pw)) << {off, 3'b000});
    push = 1'b0;
    pop = 1'b0;
    next_st = st;
    next_wbuf = wbuf;
    next_wbHead = wbHead;
    next_wbTail = wbTail;
    next_rbuf = rbuf;
    next_wordCnt = wordCnt;
    next_beatCnt = beatCnt;
    next_turnCnt = turnCnt;
    next_asmWord = asmWord;
    next_curAddr = curAddr;
    next_curWData = curWData;
    next_curBe = curBe;
    next_curWrite = curWrite;
    next_curQuad = curQuad;
    next_curIsIf = curIsIf;
    next_curFill = curFill;
    next_icVld = icVld;
    next_dcVld = dcVld;
    next_ifData = ifData;
    next_dReadData = dReadData;
    next_ifValid = 1'b0;
    next_dValid = 1'b0;
    // Hits and stores answered straight from the core side
    if (ifReq && !ifValid && icHit)
    begin
      next_ifValid = 1'b1;
      next_ifData = icData[{ifAddr[`CBI_IC_LIDX], ifAddr[`CBI_WSEL]}];
    end
    if (dReq && !dValid && !dWrite && !dUncached && dcHit)
    begin
      next_dValid = 1'b1;
      next_dReadData = dcData[dAddr[`CBI_DC_IDX]];
    end
    if (dReq && !dValid && dWrite && !dStall)
    begin
      push = 1'b1;
      next_dValid = 1'b1;
      next_wbuf[wbTail] = '{addr: dAddr, data: dWriteData, be: dByteEn};
      next_wbTail = wbTail + 2'd1;
    end
    unique case (st)
      ST_IDLE:
      begin
        if (busReq)
          next_st = ST_GRANT;
        else if (wbCount != 3'h0)
        begin
          next_st = ST_ADDR;
          next_curWrite = 1'b1;
          next_curAddr = wbuf[wbHead].addr;
          next_curWData = wbuf[wbHead].data;
          next_curBe = wbuf[wbHead].be;
          next_curQuad = 1'b0;
          next_wordCnt = wbuf[wbHead].addr[`CBI_WSEL];
        end
        else if (dReq && !dValid && !dWrite && (dUncached || !dcHit))
        begin
          next_st = ST_ADDR;
          next_curWrite = 1'b0;
          next_curIsIf = 1'b0;
          next_curFill = !dUncached;
          next_curQuad = !dUncached && ctrl.refill4;
          next_curAddr = dAddr;
          next_curBe = 4'hF;
          next_wordCnt = (!dUncached && ctrl.refill4) ? 2'b00 : dAddr[`CBI_WSEL];
        end
        else if (ifReq && !ifValid && !icHit)
        begin
          next_st = ST_ADDR;
          next_curWrite = 1'b0;
          next_curIsIf = 1'b1;
          next_curFill = 1'b1;
          next_curQuad = 1'b1;
          next_curAddr = ifAddr;
          next_curBe = 4'hF;
          next_wordCnt = 2'b00;
        end
        next_beatCnt = 2'b00;
        next_asmWord = 32'h0000_0000;
      end
      ST_ADDR:
        next_st = ctrl.extHold ? ST_HOLD : ST_DATA;
      ST_HOLD:
        next_st = ST_DATA;
      ST_DATA:
      begin
        if (ackIn)
        begin
          if (beatCnt != lastBeat(pw))
          begin
            next_beatCnt = beatCnt + 2'd1;
            next_asmWord = word;
            next_st = (ctrl.burst && !curWrite) ? ST_DATA : ST_ADDR;
          end
          else if (curWrite)
          begin
            pop = 1'b1;
            next_wbHead = wbHead + 2'd1;
            next_st = ST_IDLE;
          end
          else
          begin
            next_rbuf[wordCnt] = word;
            next_asmWord = 32'h0000_0000;
            next_beatCnt = 2'b00;
            if (!curQuad || wordCnt == 2'b11)
              next_st = ST_FILL;
            else
            begin
              next_wordCnt = wordCnt + 2'd1;
              next_st = ctrl.burst ? ST_DATA : ST_ADDR;
            end
          end
        end
      end
      ST_FILL:
      begin
        if (curIsIf)
        begin
          next_icVld[curAddr[`CBI_IC_LIDX]] = 1'b1;
          next_ifValid = 1'b1;
          next_ifData = rbuf[curAddr[`CBI_WSEL]];
        end
        else
        begin
          for (int i = 0; i < `CBI_LINE_WORDS; i++)
            if (curFill && (curQuad || 2'(i) == curAddr[`CBI_WSEL]))
              next_dcVld[{curAddr[`CBI_DC_QIDX], 2'(i)}] = 1'b1;
          next_dValid = 1'b1;
          next_dReadData = rbuf[curAddr[`CBI_WSEL]];
        end
        next_turnCnt = ctrl.turnExtra;
        next_st = (ctrl.turnExtra != 2'b00) ? ST_TURN : ST_IDLE;
      end
      ST_TURN:
      begin
        next_turnCnt = turnCnt - 2'd1;
        if (turnCnt == 2'd1)
          next_st = ST_IDLE;
      end
      ST_GRANT:
        if (!busReq)
          next_st = ST_IDLE;
    endcase
    next_wbCount = wbCount + {2'b00, push} - {2'b00, pop};
    next_dStall = next_wbCount == `CBI_WB_DEPTH;
    // Pins for the state being entered
    npw = widthOf(next_curAddr, portCfg);
    off = beatOff(npw, next_beatCnt);
    next_ale = next_st == ST_ADDR;
    next_adOe = next_st == ST_ADDR || next_st == ST_HOLD || (next_st == ST_DATA && next_curWrite);
    next_adOut = (next_st == ST_DATA)
      ? (next_curWrite ? next_curWData >> {off, 3'b000} : adOut)
      : {next_curAddr[`CBI_LINE_HI], next_wordCnt, 2'b00} + {30'h0000_0000, off};
    next_rdN = !(next_st == ST_DATA && !next_curWrite);
    next_wrN = !(next_st == ST_DATA && next_curWrite);
    next_byteEnN = (next_st == ST_ADDR || next_st == ST_HOLD || next_st == ST_DATA)
      ? ~(next_curBe >> off) : 4'hF;
    next_memStrobeN = !(next_st == ST_DATA && (ctrl.strobeMode == CBI_SM_BOTH
      || (ctrl.strobeMode == CBI_SM_READ && !next_curWrite)
      || (ctrl.strobeMode == CBI_SM_WRITE && next_curWrite)));
    next_busGnt = next_st == ST_GRANT;
    next_ctlOe = next_st != ST_GRANT;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= ST_IDLE;
      for (int i = 0; i < `CBI_LINE_WORDS; i++)
      begin
        wbuf[i] <= '0;
        rbuf[i] <= 32'h0000_0000;
      end
      {wbHead, wbTail, wbCount, wordCnt, beatCnt, turnCnt} <= '0;
      {asmWord, curAddr, curWData, curBe} <= '0;
      {curWrite, curQuad, curIsIf, curFill} <= '0;
      icVld <= '0;
      dcVld <= '0;
      {ifData, dReadData, adOut} <= '0;
      {ifValid, dValid, dStall, adOe, ale, busGnt} <= '0;
      {rdN, wrN, memStrobeN, ctlOe} <= 4'hF;
      byteEnN <= 4'hF;
    end
    else
    begin
      st <= next_st;
      wbuf <= next_wbuf;
      rbuf <= next_rbuf;
      {wbHead, wbTail, wbCount, wordCnt, beatCnt, turnCnt} <=
        {next_wbHead, next_wbTail, next_wbCount, next_wordCnt, next_beatCnt, next_turnCnt};
      {asmWord, curAddr, curWData, curBe} <= {next_asmWord, next_curAddr, next_curWData, next_curBe};
      {curWrite, curQuad, curIsIf, curFill} <= {next_curWrite, next_curQuad, next_curIsIf, next_curFill};
      icVld <= next_icVld;
      dcVld <= next_dcVld;
      {ifData, dReadData, adOut} <= {next_ifData, next_dReadData, next_adOut};
      {ifValid, dValid, dStall, adOe, ale, busGnt} <=
        {next_ifValid, next_dValid, next_dStall, next_adOe, next_ale, next_busGnt};
      {rdN, wrN, memStrobeN, ctlOe} <= {next_rdN, next_wrN, next_memStrobeN, next_ctlOe};
      byteEnN <= next_byteEnN;
    end
  end

endmodule

// file: test/cbi_props.sv
// Bus timing checks bound to the cache and bus block
`timescale 1ns/1ps
module cbi_props
  import cbi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avAddress,
  input wire logic avWrite,
  input wire logic [31:0] avWriteData,
  input wire logic avWaitRequest,
  input wire logic [31:0] adOut,
  input wire logic adOe,
  input wire logic ale,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic memStrobeN,
  input wire logic [3:0] byteEnN,
  input wire logic ctlOe,
  input wire logic ackIn,
  input wire logic busReq,
  input wire logic busGnt
);
  logic [6:0] ctrl;
  logic [6:0] ctrlPin;
  // Shadow of the control bits; ctrlPin lags one edge like the registered pins
  always_ff @(posedge clk)
    if (rst)
    begin
      ctrl <= '0;
      ctrlPin <= '0;
    end
    else
    begin
      if (avWrite && !avWaitRequest && avAddress == 4'h0)
        ctrl <= avWriteData[6:0];
      ctrlPin <= ctrl;
    end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ale_single: assert property (ale |=> !ale) else $error("ale too long");
  a_ale_drives: assert property (ale |-> adOe && ctlOe && rdN && wrN) else $error("address undriven");
  a_read_float: assert property (!rdN |-> !adOe) else $error("bus driven in read");
  a_hold_addr: assert property ($fell(ale) && ctrl[1] |-> adOe && $stable(adOut) && rdN && wrN)
    else $error("address not held");
  a_no_hold: assert property ($fell(ale) && !ctrl[1] |-> !(rdN && wrN)) else $error("extra hold");
  a_beat_end: assert property (ackIn && (!wrN || (!rdN && !ctrl[2])) |=> rdN && wrN)
    else $error("strobe after ack");
  a_turn_gap: assert property ($rose(rdN) && !ale && ctrl[4:3] == 2'h3 |-> !ale [*3])
    else $error("turn short");
  a_strobe_mode: assert property ((ctrlPin[6:5] == 2'h3 || (ctrlPin[6:5] == 2'h1 && !wrN)
    || (ctrlPin[6:5] == 2'h2 && !rdN)) |-> memStrobeN) else $error("strobe in masked cycle");
  a_strobe_on: assert property (((ctrlPin[6:5] == 2'h0 && !(rdN && wrN)) || (ctrlPin[6:5] == 2'h1 && !rdN)
    || (ctrlPin[6:5] == 2'h2 && !wrN)) |-> !memStrobeN) else $error("strobe missing");
  a_lanes_idle: assert property (rdN && wrN && !ale && !adOe |-> byteEnN == 4'hF)
    else $error("lanes active when idle");
  a_grant_quiet: assert property (busGnt |-> !adOe && !ctlOe && !ale && rdN && wrN) else $error("drives in grant");
  a_grant_drop: assert property (busGnt && !busReq |=> !busGnt) else $error("grant kept");
  c_grant: cover property (busGnt);
  c_hold: cover property ($fell(ale) && ctrl[1]);
  c_burst: cover property (!rdN && ackIn ##1 !rdN && ackIn);
endmodule
bind cbi_cache_bus cbi_props u_props (.clk(clk), .rst(rst), .avAddress(avAddress), .avWrite(avWrite),
  .avWriteData(avWriteData), .avWaitRequest(avWaitRequest), .adOut(adOut), .adOe(adOe), .ale(ale),
  .rdN(rdN), .wrN(wrN), .memStrobeN(memStrobeN), .byteEnN(byteEnN), .ctlOe(ctlOe), .ackIn(ackIn),
  .busReq(busReq), .busGnt(busGnt));

// file: test/cbi_mem_model.sv
// Behavioural memory on the multiplexed bus
`timescale 1ns/1ps
module cbi_mem_model
  import cbi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ale,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic [31:0] adOut,
  input wire logic adOe,
  input wire logic [3:0] waitCyc,
  output logic ackIn,
  output logic [31:0] adIn
);
  logic [31:0] addr;
  logic [31:0] lastAd;
  logic [3:0] cnt;
  int nRd;
  logic [31:0] wA[$];
  logic [31:0] wD[$];
  // Word content of any aligned address
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[31:2], 2'b00} ^ 32'h5A5A_C3C3;
  endfunction
  // Acknowledge once the set wait has passed
  assign ackIn = (!rdN || !wrN) && cnt == waitCyc;
  // Wire level: device, memory on low lanes, else inverted stale value
  assign adIn = adOe ? adOut : (!rdN ? pat(addr) >> {addr[1:0], 3'b000} : ~lastAd);
  // Latch address, count waits, log retired writes
  always_ff @(posedge clk)
  begin
    lastAd <= adIn;
    if (rst)
    begin
      cnt <= '0;
      nRd <= 0;
    end
    else if (ale)
    begin
      addr <= adOut;
      cnt <= '0;
    end
    else if (ackIn)
    begin
      cnt <= '0;
      addr <= addr + 32'h0000_0004;
      if (!rdN)
        nRd <= nRd + 1;
      else
      begin
        wA.push_back(addr);
        wD.push_back(adOut);
      end
    end
    else if (!rdN || !wrN)
      cnt <= cnt + 4'h1;
  end
endmodule

// file: test/cbi_cache_bus_bench.sv
// Self-checking bench for the cache and bus block
`timescale 1ns/1ps
module cbi_cache_bus_bench import cbi_pkg::*;;
  logic clk = 0, rst = 1, avRead = 0, avWrite = 0, ifReq = 0, dReq = 0, dWrite = 0, dUncached = 0, busReq = 0;
  logic [3:0] avAddress = '0, dByteEn = 4'hF, waitCyc = '0, byteEnN;
  logic [31:0] avWriteData = '0, ifAddr = '0, dAddr = '0, dWriteData = '0;
  logic [31:0] avReadData, ifData, dReadData, adIn, adOut, q;
  logic avWaitRequest, ifValid, dValid, dStall, adOe, ale, rdN, wrN, memStrobeN, ctlOe, ackIn, busGnt;
  int mismatches = 0, comparisons = 0;
  always #25 clk = ~clk;
  cbi_cache_bus dut (.clk, .rst, .avAddress, .avRead, .avWrite, .avWriteData, .avReadData, .avWaitRequest,
    .ifReq, .ifAddr, .ifData, .ifValid, .dReq, .dWrite, .dUncached, .dAddr, .dWriteData, .dByteEn, .dReadData,
    .dValid, .dStall, .adIn, .adOut, .adOe, .ale, .rdN, .wrN, .byteEnN, .memStrobeN, .ctlOe, .ackIn, .busReq, .busGnt);
  cbi_mem_model mem (.clk, .rst, .ale, .rdN, .wrN, .adOut, .adOe, .waitCyc, .ackIn, .adIn);
  // Reporting helpers
  task automatic bad(input string m);
    mismatches++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  function automatic bit ne(input logic [31:0] a, input logic [31:0] b);
    comparisons++;
    return a !== b;
  endfunction
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Register access, held until waitrequest is seen low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avAddress <= a;
    avWriteData <= d;
    avWrite <= w;
    avRead <= !w;
    @(posedge clk);
    while (avWaitRequest !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    q = avReadData;
    avWrite <= 0;
    avRead <= 0;
    if (n >= 50) bad("register timeout");
  endtask
  // Core fetch or data request, held until its valid pulse
  task automatic core(input bit f, input bit w, input bit u, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    ifReq <= f;
    ifAddr <= a;
    dReq <= !f;
    dWrite <= w;
    dUncached <= u;
    dAddr <= a;
    dWriteData <= d;
    @(posedge clk);
    while ((f ? ifValid : dValid) !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    q = f ? ifData : dReadData;
    ifReq <= 0;
    dReq <= 0;
    if (n >= 400) bad("core timeout");
  endtask
  // Read, then judge data and bus beats used
  task automatic rd(input bit f, input bit u, input logic [31:0] a, input int beats, input string m);
    int n0;
    n0 = mem.nRd;
    core(f, 0, u, a, '0);
    if (ne(q, mem.pat(a))) bad(m);
    if (ne(mem.nRd - n0, beats)) bad(m);
  endtask
  task automatic drain();
    for (int i = 0; i < 60; i++)
    begin
      av(0, 4'h8, '0);
      if (q[3:0] === 4'h0)
        return;
    end
    bad("buffer not drained");
  endtask
  task automatic t_reset();
    @(negedge clk);
    if (ne({avWaitRequest, rdN, wrN, byteEnN, busGnt, ctlOe, adOe}, 32'h0000_03FA)) bad("idle levels");
    av(1, 4'hC, 32'hDEAD_BEEF);
    av(0, 4'hC, '0);
    if (ne(q, '0)) bad("unmapped read");
    av(1, 4'h4, 32'h0000_0018);
    av(0, 4'h4, '0);
    if (ne(q, 32'h0000_0018)) bad("port readback");
    $display("test reset done");
  endtask
  task automatic t_caches();
    rd(1, 0, 32'h0000_0104, 4, "icache miss");
    rd(1, 0, 32'h0000_010C, 0, "icache hit");
    rd(1, 0, 32'h0000_0904, 4, "icache conflict");
    rd(1, 0, 32'hC000_0104, 4, "icache tag");
    rd(1, 0, 32'hC000_0100, 0, "icache high hit");
    rd(0, 0, 32'h0000_0040, 1, "dcache miss");
    rd(0, 0, 32'h0000_0040, 0, "dcache hit");
    rd(0, 0, 32'h0000_0240, 1, "dcache conflict");
    rd(0, 1, 32'h0000_0244, 1, "uncached");
    av(1, 4'h0, 32'h0000_0001);
    rd(0, 0, 32'h0000_0084, 4, "quad refill");
    rd(0, 0, 32'h0000_0088, 0, "quad hit");
    core(0, 1, 0, 32'h0000_0088, 32'h1234_5678);
    core(0, 0, 0, 32'h0000_0088, '0);
    if (ne(q, 32'h1234_5678)) bad("store hit");
    drain();
    if (ne(mem.wD[mem.wD.size() - 1], 32'h1234_5678)) bad("write through");
    dByteEn <= 4'h3;
    core(0, 1, 0, 32'h0000_0088, 32'hFFFF_9ABC);
    dByteEn <= 4'hF;
    core(0, 0, 0, 32'h0000_0088, '0);
    if (ne(q, 32'h1234_9ABC)) bad("byte merge");
    drain();
    av(1, 4'h0, '0);
    $display("test caches done");
  endtask
  task automatic t_wbuf();
    int n0;
    n0 = mem.wA.size();
    waitCyc <= 4'hF;
    for (int i = 0; i < 5; i++)
    begin
      core(0, 1, 0, 32'h0000_0300 + 4 * i, 32'hA5A5_0000 + i);
      @(negedge clk);
      if (i > 1 && i < 4 && ne(dStall, i == 3)) bad("stall level");
    end
    drain();
    for (int i = 0; i < 5; i++)
      if (ne(mem.wA[n0 + i], 32'h0000_0300 + 4 * i) || ne(mem.wD[n0 + i], 32'hA5A5_0000 + i)) bad("fifo order");
    waitCyc <= 4'h2;
    $display("test write buffer done");
  endtask
  task automatic t_narrow();
    int n0;
    rd(0, 1, 32'h4000_0010, 4, "byte port");
    rd(0, 1, 32'h8000_0020, 2, "half port");
    rd(1, 0, 32'h4000_0208, 16, "byte fetch");
    n0 = mem.wA.size();
    core(0, 1, 1, 32'h8000_0030, 32'hCAFE_F00D);
    drain();
    if (ne(mem.wA[n0 + 1], 32'h8000_0032) || ne(mem.wD[n0][15:0], 16'hF00D)) bad("split write");
    if (ne(mem.wD[n0 + 1][15:0], 16'hCAFE)) bad("split write");
    waitCyc <= '0;
    $display("test narrow done");
  endtask
  task automatic t_timing();
    av(1, 4'h0, 32'h0000_003E);
    rd(1, 0, 32'h0000_0500, 4, "burst fill");
    core(0, 1, 1, 32'h0000_0600, 32'h0F0F_0F0F);
    for (int m = 0; m < 4; m++)
    begin
      av(1, 4'h0, 32'h0000_0002 | (m << 5));
      rd(0, 1, 32'h0000_0700, 1, "strobe mode");
      core(0, 1, 1, 32'h0000_0700, 32'h0000_00AA);
      drain();
    end
    $display("test timing done");
  endtask
  task automatic t_grant();
    int n;
    n = 0;
    @(posedge clk);
    busReq <= 1;
    @(posedge clk);
    while (busGnt !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (ne({busGnt, ctlOe, adOe}, 32'h0000_0004)) bad("grant");
    busReq <= 0;
    repeat (2) @(posedge clk);
    if (ne({busGnt, ctlOe}, 32'h0000_0001)) bad("release");
    $display("test grant done");
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 0;
    t_reset();
    t_caches();
    t_wbuf();
    t_narrow();
    t_timing();
    t_grant();
    end_sim();
  end
  // Watchdog
  initial
  begin
    #2000000;
    bad("watchdog");
    end_sim();
  end
endmodule
